// [efs_event_logic.sv]
// Behaviour
// - crc multiframe loss state bit readable
// - offline frame loss state bit readable
// - basic frame loss state bit readable
// - change flag on any state toggle
// - flags stay set until written one
// - interrupt only for enabled flags; enables reset 0
// - 915 crc errors per second window
// - excess detection suspended when crc unsynced
// - cas multiframe start flag, gated by sync
// - crc sub-multiframe start flag, gated by sync
// - crc multiframe start flag, gated by sync
// - cas alignment word must equal 0000
// - crc alignment bits must equal 001011
// - crc-4 check against next sub-multiframe
// - frame word error per selected criterion
// - flag when alignment position moves
// - count select: words (bits select stored only), add nonalign
// - interworking state bit readable
// - cas multiframe loss state bit readable
`timescale 1ns/100ps
`default_nettype none
module efs_event_logic #(
  parameter int WINDOW_CYCLES = efs_pkg::WINDOW_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire efs_pkg::efs_bus_type   bus,
  output logic [efs_pkg::DATA_W-1:0]  rd_data,
  input  wire efs_pkg::efs_state_type state_in,
  input  wire logic                   cas_mf_start,
  input  wire logic                   crc_submf_start,
  input  wire logic                   crc_mf_start,
  input  wire logic                   cas_mfas_valid,
  input  wire logic [3:0]             cas_mfas,
  input  wire logic                   crc_mfas_valid,
  input  wire logic [5:0]             crc_mfas,
  input  wire logic                   fas_valid,
  input  wire logic [6:0]             fas_word,
  input  wire logic                   nfas_valid,
  input  wire logic                   nfas_bit,
  input  wire logic                   rx_bit_en,
  input  wire logic                   rx_bit,
  input  wire logic                   crc_bit_slot,
  input  wire logic                   align_found,
  input  wire logic [efs_pkg::POS_W-1:0] align_pos,
  output logic                        irq_n
);

  efs_pkg::efs_state_type      status;
  logic [5:0]                  enable0;
  logic [7:0]                  enable1;
  logic [5:0]                  flags0;
  logic [7:0]                  flags1;
  logic                        pattern_count_select;
  logic                        nonalign_count_select;
  logic [5:0]                  set0;
  logic [7:0]                  set1;
  logic [5:0]                  clr0;
  logic [7:0]                  clr1;
  logic                        crc_sync;
  logic                        cas_sync;
  logic                        frame_sync;
  logic                        word_err_evt;
  logic                        crc_err_evt;
  logic                        excess_evt;
  logic [3:0]                  crc_calc;
  logic [3:0]                  crc_prev;
  logic [3:0]                  crc_rx;
  logic                        crc_have;
  logic [3:0]                  next_calc;
  logic [3:0]                  next_rx;
  logic [3:0]                  base_calc;
  logic [3:0]                  base_rx;
  logic                        fb;
  logic [9:0]                  err_count;
  logic [26:0]                 win_count;
  logic [efs_pkg::POS_W-1:0]   last_pos;
  logic                        pos_valid;
  logic                        pending;

  // sync conditions taken from the live state
  assign crc_sync   = !state_in.crc_mf_loss_state;
  assign cas_sync   = !state_in.cas_mf_loss_state;
  assign frame_sync = !state_in.frame_loss_state;

  // registered copy of the state bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= efs_pkg::STATUS_RESET;
    end else begin
      status <= state_in;
    end
  end

  // enable and mode registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable0               <= efs_pkg::ENABLE0_RESET;
      enable1               <= efs_pkg::ENABLE1_RESET;
      pattern_count_select  <= 1'b0;
      nonalign_count_select <= 1'b0;
    end else if (bus.wr) begin
      if (bus.addr == efs_pkg::OFS_ENABLE_0) begin
        enable0 <= bus.wdata[5:0];
      end
      if (bus.addr == efs_pkg::OFS_ENABLE_1) begin
        enable1 <= bus.wdata;
      end
      if (bus.addr == efs_pkg::OFS_MODE) begin
        pattern_count_select  <= bus.wdata[efs_pkg::MODE_PATTERN];
        nonalign_count_select <= bus.wdata[efs_pkg::MODE_NONALIGN];
      end
    end
  end

  // frame word error: whole fas word, optionally nfas
  always_comb begin
    word_err_evt = 1'b0;
    if (frame_sync) begin
      if (fas_valid && fas_word != efs_pkg::FAS_WORD) begin
        word_err_evt = 1'b1;
      end
      if (nonalign_count_select && nfas_valid && !nfas_bit) begin
        word_err_evt = 1'b1;
      end
    end
  end

  // serial crc-4, c-bit slots counted as zero
  always_comb begin
    base_calc = crc_submf_start ? 4'h0 : crc_calc;
    base_rx   = crc_submf_start ? 4'h0 : crc_rx;
    next_calc = base_calc;
    next_rx   = base_rx;
    fb        = 1'b0;
    if (rx_bit_en) begin
      fb        = (rx_bit & !crc_bit_slot) ^ base_calc[3];
      next_calc = {base_calc[2:0], 1'b0} ^
                  (fb ? efs_pkg::CRC_POLY_LOW : 4'h0);
      if (crc_bit_slot) begin
        next_rx = {base_rx[2:0], rx_bit};
      end
    end
  end

  assign crc_err_evt = crc_sync && crc_submf_start && crc_have &&
                       crc_rx != crc_prev;

  // crc-4 state; compare restarts whenever sync is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_calc <= 4'h0;
      crc_rx   <= 4'h0;
      crc_prev <= 4'h0;
      crc_have <= 1'b0;
    end else begin
      crc_calc <= next_calc;
      crc_rx   <= next_rx;
      if (!crc_sync) begin
        crc_have <= 1'b0;
      end else if (crc_submf_start) begin
        crc_prev <= crc_calc;
        crc_have <= 1'b1;
      end
    end
  end

  // one second window of crc-4 errors
  assign excess_evt = crc_sync && crc_err_evt &&
                      err_count == efs_pkg::EXCESS_LIMIT - 10'h001;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_count <= 27'h0;
      err_count <= 10'h0;
    end else if (!crc_sync) begin
      win_count <= 27'h0;
      err_count <= 10'h0;
    end else if (win_count == 27'(WINDOW_CYCLES - 1)) begin
      win_count <= 27'h0;
      err_count <= 10'h0;
    end else begin
      win_count <= win_count + 27'h1;
      if (crc_err_evt && err_count != efs_pkg::EXCESS_LIMIT) begin
        err_count <= err_count + 10'h1;
      end
    end
  end

  // last alignment position
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_pos  <= '0;
      pos_valid <= 1'b0;
    end else if (align_found) begin
      last_pos  <= align_pos;
      pos_valid <= 1'b1;
    end
  end

  // hardware set terms
  always_comb begin
    set0 = 6'h00;
    set0[4:0] = state_in ^ status;
    set0[efs_pkg::F0_EXCESS] = excess_evt;
    set1 = 8'h00;
    set1[efs_pkg::F1_CAS_START] = cas_sync && cas_mf_start;
    set1[efs_pkg::F1_SUB_START] = crc_sync && crc_submf_start;
    set1[efs_pkg::F1_CRC_START] = crc_sync && crc_mf_start;
    set1[efs_pkg::F1_CAS_ERR]   = cas_sync && cas_mfas_valid &&
                                  cas_mfas != efs_pkg::CAS_MFAS;
    set1[efs_pkg::F1_CRC_ALIGN] = crc_sync && crc_mfas_valid &&
                                  crc_mfas != efs_pkg::CRC_MFAS;
    set1[efs_pkg::F1_CRC_ERR]   = crc_err_evt;
    set1[efs_pkg::F1_WORD_ERR]  = word_err_evt;
    set1[efs_pkg::F1_MOVE]      = align_found && pos_valid &&
                                  align_pos != last_pos;
  end

  // write-one-to-clear terms
  assign clr0 = (bus.wr && bus.addr == efs_pkg::OFS_FLAGS_0) ?
                bus.wdata[5:0] : 6'h00;
  assign clr1 = (bus.wr && bus.addr == efs_pkg::OFS_FLAGS_1) ?
                bus.wdata : 8'h00;

  // sticky flags, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags0 <= efs_pkg::FLAGS0_RESET;
      flags1 <= efs_pkg::FLAGS1_RESET;
    end else begin
      flags0 <= (flags0 & ~clr0) | set0;
      flags1 <= (flags1 & ~clr1) | set1;
    end
  end

  // interrupt output
  assign pending = |(flags0 & enable0) || |(flags1 & enable1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !pending;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        efs_pkg::OFS_MODE: begin
          rd_data <= {3'h0, nonalign_count_select,
                      pattern_count_select, 3'h0};
        end
        efs_pkg::OFS_STATUS:   rd_data <= {3'h0, status};
        efs_pkg::OFS_ENABLE_0: rd_data <= {2'h0, enable0};
        efs_pkg::OFS_ENABLE_1: rd_data <= enable1;
        efs_pkg::OFS_FLAGS_0:  rd_data <= {2'h0, flags0};
        efs_pkg::OFS_FLAGS_1:  rd_data <= flags1;
        default:               rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cas_bad;
    cas_mfas_valid && !state_in.cas_mf_loss_state &&
    cas_mfas != efs_pkg::CAS_MFAS;
  endsequence

  sequence s_crc_bad;
    crc_mfas_valid && !state_in.crc_mf_loss_state &&
    crc_mfas != efs_pkg::CRC_MFAS;
  endsequence

  sequence s_flag_cleared(int b);
    bus.wr && bus.addr == efs_pkg::OFS_FLAGS_1 && bus.wdata[b] &&
    !set1[b];
  endsequence

  a_status_follow: assert property (
    ##1 status.frame_loss_state == $past(state_in.frame_loss_state))
    else $error("frame loss status bit stale");

  a_frame_change: assert property (
    state_in.frame_loss_state != status.frame_loss_state |=>
    flags0[0])
    else $error("frame change flag missed");

  a_move_clear: assert property (
    s_flag_cleared(efs_pkg::F1_MOVE) |=> !flags1[efs_pkg::F1_MOVE])
    else $error("move flag not cleared by write one");

  a_flag_hold: assert property (
    flags1[efs_pkg::F1_CRC_ERR] && !clr1[efs_pkg::F1_CRC_ERR] |=>
    flags1[efs_pkg::F1_CRC_ERR])
    else $error("crc error flag dropped without write");

  a_irq_follow: assert property (
    pending |=> !irq_n ##1 (irq_n == !$past(pending)))
    else $error("interrupt output does not follow flags");

  a_irq_quiet: assert property (
    ((flags0 & enable0) == 6'h00 && (flags1 & enable1) == 8'h00)
    |=> irq_n)
    else $error("interrupt asserted with no enabled flag");

  a_cas_error: assert property (
    s_cas_bad |=> flags1[efs_pkg::F1_CAS_ERR])
    else $error("cas alignment error not flagged");

  a_crc_align: assert property (
    s_crc_bad |=> flags1[efs_pkg::F1_CRC_ALIGN])
    else $error("crc alignment error not flagged");

  a_start_gate: assert property (
    state_in.crc_mf_loss_state && !flags1[efs_pkg::F1_CRC_START]
    |=> !flags1[efs_pkg::F1_CRC_START])
    else $error("crc multiframe start flag set out of sync");

  a_excess_hit: assert property (
    excess_evt |=> flags0[efs_pkg::F0_EXCESS] &&
    err_count == ((win_count == 27'h0) ? 10'h000 : efs_pkg::EXCESS_LIMIT))
    else $error("excess crc flag missed at limit");

  a_excess_susp: assert property (
    state_in.crc_mf_loss_state |=> err_count == 10'h0 &&
    win_count == 27'h0)
    else $error("excess crc counting while out of sync");

  a_align_move: assert property (
    align_found && pos_valid && align_pos != last_pos |=>
    flags1[efs_pkg::F1_MOVE] && last_pos == $past(align_pos))
    else $error("alignment move not flagged");

  // every state bit reads back one cycle late
  a_status_all: assert property (
    ##1 status == $past(state_in))
    else $error("status register stale");

  // each toggled state bit leaves its change flag set
  a_change_all: assert property (
    (state_in ^ status) != 5'h00 |=>
    (flags0[4:0] & $past(state_in ^ status)) ==
    $past(state_in ^ status))
    else $error("state change flag missed");

  a_cas_gate: assert property (
    state_in.cas_mf_loss_state && !flags1[efs_pkg::F1_CAS_START]
    |=> !flags1[efs_pkg::F1_CAS_START])
    else $error("cas multiframe start flag set out of sync");

  a_sub_gate: assert property (
    state_in.crc_mf_loss_state && !flags1[efs_pkg::F1_SUB_START]
    |=> !flags1[efs_pkg::F1_SUB_START])
    else $error("crc sub-multiframe start flag set out of sync");

  a_crc_gate: assert property (
    state_in.crc_mf_loss_state && !flags1[efs_pkg::F1_CRC_ERR]
    |=> !flags1[efs_pkg::F1_CRC_ERR])
    else $error("crc error flag set out of sync");

  a_word_gate: assert property (
    state_in.frame_loss_state && !flags1[efs_pkg::F1_WORD_ERR]
    |=> !flags1[efs_pkg::F1_WORD_ERR])
    else $error("frame word error flag set out of sync");

endmodule
`default_nettype wire

// [efs_pkg.sv]
package efs_pkg;

  // register map and data widths
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  OFS_MODE      = 8'h4E;
  localparam logic [7:0]  OFS_STATUS    = 8'h4F;
  localparam logic [7:0]  OFS_ENABLE_0  = 8'h50;
  localparam logic [7:0]  OFS_ENABLE_1  = 8'h51;
  localparam logic [7:0]  OFS_FLAGS_0   = 8'h52;
  localparam logic [7:0]  OFS_FLAGS_1   = 8'h53;

  // reset values
  localparam logic [4:0]  STATUS_RESET  = 5'h0D;
  localparam logic [5:0]  ENABLE0_RESET = 6'h00;
  localparam logic [7:0]  ENABLE1_RESET = 8'h00;
  localparam logic [5:0]  FLAGS0_RESET  = 6'h00;
  localparam logic [7:0]  FLAGS1_RESET  = 8'h00;

  // mode register fields
  localparam int          MODE_NONALIGN = 4;
  localparam int          MODE_PATTERN  = 3;

  // indication 0 fields (change flags follow status bit order)
  localparam int          F0_EXCESS     = 5;

  // indication 1 fields
  localparam int          F1_CAS_START  = 7;
  localparam int          F1_SUB_START  = 6;
  localparam int          F1_CAS_ERR    = 5;
  localparam int          F1_CRC_START  = 4;
  localparam int          F1_CRC_ALIGN  = 3;
  localparam int          F1_CRC_ERR    = 2;
  localparam int          F1_WORD_ERR   = 1;
  localparam int          F1_MOVE       = 0;

  // expected line patterns
  localparam logic [6:0]  FAS_WORD      = 7'h1B;
  localparam logic [3:0]  CAS_MFAS      = 4'h0;
  localparam logic [5:0]  CRC_MFAS      = 6'h0B;
  localparam logic [3:0]  CRC_POLY_LOW  = 4'h3;
  localparam int          POS_W         = 9;

  // excessive crc-4 error window
  localparam logic [9:0]  EXCESS_LIMIT  = 10'h393;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          WINDOW_MS     = 1000;
  localparam int          WINDOW_CYCLES =
    WINDOW_MS * (1000000 / CLK_PERIOD_NS);

  // synchronisation state from the frame search logic
  typedef struct packed {
    logic interworking_state;
    logic cas_mf_loss_state;
    logic crc_mf_loss_state;
    logic offline_frame_loss_state;
    logic frame_loss_state;
  } efs_state_type;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } efs_bus_type;

endpackage

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                   clk;
  logic                   rst;
  efs_pkg::efs_bus_type   bus;
  logic [7:0]             rd_data;
  efs_pkg::efs_state_type state_in;
  logic [7:0]             pv;
  logic [3:0]             cas_mfas;
  logic [5:0]             crc_mfas;
  logic [6:0]             fas_word;
  logic                   nfas_bit;
  logic                   rx_bit_en;
  logic                   rx_bit;
  logic                   crc_bit_slot;
  logic [8:0]             align_pos;
  logic                   irq_n;
  logic [7:0]             rv;
  int                     error_cnt;
  int                     checked;

  // short excess window keeps the error burst test brief
  efs_event_logic #(.WINDOW_CYCLES(20000)) i_efs_event_logic (
    .clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data),
    .state_in(state_in), .cas_mf_start(pv[0]), .crc_submf_start(pv[1]),
    .crc_mf_start(pv[2]), .cas_mfas_valid(pv[3]), .cas_mfas(cas_mfas),
    .crc_mfas_valid(pv[4]), .crc_mfas(crc_mfas), .fas_valid(pv[5]),
    .fas_word(fas_word), .nfas_valid(pv[6]), .nfas_bit(nfas_bit),
    .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .crc_bit_slot(crc_bit_slot),
    .align_found(pv[7]), .align_pos(align_pos), .irq_n(irq_n));

  // clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask

  // read data is taken in the cycle after the strobe only
  task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e, input string n);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    #1 rv = rd_data;
    chk(n, rv & m, e);
  endtask

  task automatic ichk(input logic e);
    repeat (3) @(posedge clk);
    #1 chk("irq_n", {7'h00, irq_n}, {7'h00, e});
  endtask

  task automatic set_state(input logic [4:0] v);
    @(posedge clk);
    state_in <= v;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    pv <= 8'h01 << k;
    @(posedge clk);
    pv <= 8'h00;
  endtask

  // one short sub-multiframe: four c bits then one zero data bit
  task automatic submf(input logic [3:0] c);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      rx_bit_en    <= 1'b1;
      crc_bit_slot <= (i < 4);
      rx_bit       <= (i < 4) ? c[3-i] : 1'b0;
      pv[1]        <= (i == 0);
    end
    @(posedge clk);
    rx_bit_en    <= 1'b0;
    crc_bit_slot <= 1'b0;
    pv[1]        <= 1'b0;
  endtask

  task automatic test_reset;
    rchk(efs_pkg::OFS_STATUS, 8'hFF, 8'h0D, "status");
    rchk(efs_pkg::OFS_ENABLE_0, 8'hFF, 8'h00, "enable0");
    rchk(efs_pkg::OFS_ENABLE_1, 8'hFF, 8'h00, "enable1");
    rchk(efs_pkg::OFS_FLAGS_0, 8'hFF, 8'h00, "flags0");
    rchk(efs_pkg::OFS_FLAGS_1, 8'hFF, 8'h00, "flags1");
    rchk(8'h60, 8'hFF, 8'h00, "unmapped");
    wr(efs_pkg::OFS_STATUS, 8'hFF);
    rchk(efs_pkg::OFS_STATUS, 8'hFF, 8'h0D, "status ro");
    wr(efs_pkg::OFS_ENABLE_1, 8'hA5);
    rchk(efs_pkg::OFS_ENABLE_1, 8'hFF, 8'hA5, "enable1 rw");
    wr(efs_pkg::OFS_ENABLE_1, 8'h00);
    ichk(1'b1);
    $display("test reset done");
  endtask

  // toggle each state bit, check flag, masking, hold and clear
  task automatic test_state;
    logic [7:0] m;
    logic [4:0] st;
    st = 5'h0D;
    for (int i = 0; i < 5; i++) begin
      m = 8'h01 << i;
      st = st ^ m[4:0];
      set_state(st);
      rchk(efs_pkg::OFS_STATUS, 8'hFF, {3'h0, st}, "status");
      rchk(efs_pkg::OFS_FLAGS_0, 8'hFF, m, "change flag");
      wr(efs_pkg::OFS_ENABLE_0, ~m & 8'h3F);
      ichk(1'b1);
      wr(efs_pkg::OFS_ENABLE_0, m);
      ichk(1'b0);
      wr(efs_pkg::OFS_FLAGS_0, ~m);
      rchk(efs_pkg::OFS_FLAGS_0, 8'hFF, m, "flag held");
      ichk(1'b0);
      wr(efs_pkg::OFS_FLAGS_0, m);
      ichk(1'b1);
      rchk(efs_pkg::OFS_FLAGS_0, 8'hFF, 8'h00, "flag cleared");
    end
    wr(efs_pkg::OFS_ENABLE_0, 8'h00);
    $display("test state done");
  endtask

  // start flags ignored while out of multiframe sync
  task automatic test_gated;
    logic [7:0] e;
    for (int k = 0; k < 3; k++) begin
      e = (k == 0) ? 8'h80 : (k == 1) ? 8'h40 : 8'h10;
      set_state(5'h1E);
      pulse(k);
      rchk(efs_pkg::OFS_FLAGS_1, 8'hFF, 8'h00, "start gated");
      set_state(5'h12);
      pulse(k);
      rchk(efs_pkg::OFS_FLAGS_1, 8'hFF, e, "start flag");
      wr(efs_pkg::OFS_FLAGS_1, 8'hFF);
    end
    $display("test gated done");
  endtask

  task automatic pat(input int k, input logic [7:0] md, input logic g,
                     input logic [7:0] e);
    wr(efs_pkg::OFS_MODE, md);
    cas_mfas <= g ? 4'h0 : 4'h8;
    crc_mfas <= g ? 6'h0B : 6'h0A;
    fas_word <= g ? 7'h1B : 7'h1A;
    nfas_bit <= g;
    pulse(k);
    rchk(efs_pkg::OFS_FLAGS_1, 8'hFF, e, "pattern flag");
    wr(efs_pkg::OFS_FLAGS_1, 8'hFF);
  endtask

  task automatic test_pattern;
    pat(3, 8'h00, 1'b1, 8'h00);
    pat(3, 8'h00, 1'b0, 8'h20);
    pat(4, 8'h00, 1'b1, 8'h00);
    pat(4, 8'h00, 1'b0, 8'h08);
    pat(5, 8'h00, 1'b1, 8'h00);
    pat(5, 8'h00, 1'b0, 8'h02);
    pat(5, 8'h08, 1'b0, 8'h02);
    pat(6, 8'h00, 1'b0, 8'h00);
    pat(6, 8'h10, 1'b0, 8'h02);
    pat(6, 8'h10, 1'b1, 8'h00);
    pat(5, 8'h18, 1'b0, 8'h02);
    pat(6, 8'h18, 1'b0, 8'h02);
    set_state(5'h1F);
    pat(3, 8'h00, 1'b0, 8'h00);
    pat(4, 8'h00, 1'b0, 8'h00);
    pat(5, 8'h00, 1'b0, 8'h00);
    set_state(5'h12);
    wr(efs_pkg::OFS_MODE, 8'h00);
    $display("test pattern done");
  endtask

  task automatic mv(input logic [8:0] p, input logic [7:0] e);
    @(posedge clk);
    align_pos <= p;
    pulse(7);
    rchk(efs_pkg::OFS_FLAGS_1, 8'hFF, e, "align move");
    wr(efs_pkg::OFS_FLAGS_1, 8'hFF);
  endtask

  task automatic test_move;
    mv(9'h005, 8'h00);
    mv(9'h005, 8'h00);
    mv(9'h006, 8'h01);
    $display("test move done");
  endtask

  // zero data gives a zero crc, so any nonzero c bits are errors
  task automatic test_crc;
    set_state(5'h16);
    repeat (4) submf(4'hF);
    rchk(efs_pkg::OFS_FLAGS_1, 8'h04, 8'h00, "crc gated");
    rchk(efs_pkg::OFS_FLAGS_0, 8'h20, 8'h00, "excess gated");
    set_state(5'h12);
    repeat (3) submf(4'h0);
    wr(efs_pkg::OFS_FLAGS_1, 8'hFF);
    repeat (2) submf(4'h0);
    rchk(efs_pkg::OFS_FLAGS_1, 8'h04, 8'h00, "crc clean");
    repeat (914) submf(4'hF);
    submf(4'h0);
    rchk(efs_pkg::OFS_FLAGS_1, 8'h04, 8'h04, "crc error");
    rchk(efs_pkg::OFS_FLAGS_0, 8'h20, 8'h00, "excess 914");
    submf(4'hF);
    submf(4'h0);
    rchk(efs_pkg::OFS_FLAGS_0, 8'h20, 8'h20, "excess 915");
    $display("test crc done");
  endtask

  // two enabled flags hold the interrupt until both are cleared
  task automatic test_irq;
    wr(efs_pkg::OFS_ENABLE_1, 8'h90);
    pulse(0);
    pulse(2);
    ichk(1'b0);
    wr(efs_pkg::OFS_FLAGS_1, 8'h80);
    ichk(1'b0);
    wr(efs_pkg::OFS_ENABLE_1, 8'h80);
    ichk(1'b1);
    wr(efs_pkg::OFS_ENABLE_1, 8'h90);
    wr(efs_pkg::OFS_FLAGS_1, 8'h10);
    ichk(1'b1);
    $display("test irq done");
  endtask

  // reset in mid-run clears enables, flags and mode
  task automatic test_rst;
    wr(efs_pkg::OFS_ENABLE_0, 8'h3F);
    wr(efs_pkg::OFS_MODE, 8'h18);
    set_state(5'h0D);
    ichk(1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(efs_pkg::OFS_ENABLE_0, 8'hFF, 8'h00, "enable0 reset");
    rchk(efs_pkg::OFS_ENABLE_1, 8'hFF, 8'h00, "enable1 reset");
    rchk(efs_pkg::OFS_FLAGS_0, 8'hFF, 8'h00, "flags0 reset");
    rchk(efs_pkg::OFS_MODE, 8'hFF, 8'h00, "mode reset");
    ichk(1'b1);
    $display("test rst done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    test_done;
  end

  // main sequence
  initial begin
    rst = 1'b1;
    bus = '0;
    state_in = 5'h0D;
    pv = 8'h00;
    cas_mfas = 4'h0;
    crc_mfas = 6'h0B;
    fas_word = 7'h1B;
    nfas_bit = 1'b1;
    rx_bit_en = 1'b0;
    rx_bit = 1'b0;
    crc_bit_slot = 1'b0;
    align_pos = 9'h000;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    test_reset;
    test_state;
    test_gated;
    test_pattern;
    test_move;
    test_irq;
    test_rst;
    test_crc;
    test_done;
  end
endmodule
`default_nettype wire
